// ---- design/temp_sensor_register_access.sv ----
`timescale 1ns/100ps
// How it works
// - Answer address 1001 followed by the three address select pins.
// - An 8-bit pointer byte selects the register; only two low bits count.
// - Select 00 ambient, 01 configuration, 10 hysteresis, 11 upper limit.
// - Unimplemented upper pointer bits always hold and read zero.
// - Ambient register is read-only and loaded with each converter result.
// - Upper and hysteresis limits are writable and readable by the host.
// - Alert asserts when ambient exceeds the upper limit; it releases below hysteresis.
// - Alert pin is open-drain: pulled low or released, never driven high.
// - Resolution 9 to 12 bits; conversion 30 ms up to 240 ms.
// - Serial data is two-way; device only pulls low against a pull-up.
// - Ambient is 16-bit two's complement, double-buffered for stable reads.
// - Upper limit uses nine top bits, resets to 0 1010 0000.
// - Hysteresis limit uses nine top bits, resets to 0 1001 0110.
module temp_sensor_register_access #(
  parameter int CONV9_CYC  = tsense_pkg::T9_MS * tsense_pkg::CYC_PER_MS,
  parameter int CONV10_CYC = tsense_pkg::T10_MS * tsense_pkg::CYC_PER_MS,
  parameter int CONV11_CYC = tsense_pkg::T11_MS * tsense_pkg::CYC_PER_MS,
  parameter int CONV12_CYC = tsense_pkg::T12_MS * tsense_pkg::CYC_PER_MS
) (
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial link
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address straps
  input  wire logic        addr_select_pin_hi,
  input  wire logic        addr_select_pin_mid,
  input  wire logic        addr_select_pin_lo,
  // Alert pin
  output logic             alert_out,
  output logic             alert_oe,
  // Converter
  output logic             conv_start,
  output logic [1:0]       conv_res,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data
);

  // ----------------------------------------------------------------
  // Link reset and start detection
  // ----------------------------------------------------------------
  logic                    link_rst_m;
  logic                    link_rst;
  logic                    start_tgl;
  logic                    start_ack;
  logic                    start_now;
  logic [2:0]              addr_m;
  logic [2:0]              addr_s;

  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      link_rst_m <= 1'b1;
      link_rst   <= 1'b1;
    end else begin
      link_rst_m <= 1'b0;
      link_rst   <= link_rst_m;
    end
  end

  // Start is sda falling while scl high; the bus timing gives setup to scl
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tgl <= 1'b0;
    end else if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  assign start_now = start_tgl ^ start_ack;

  always_ff @(posedge scl) begin
    addr_m <= {addr_select_pin_hi, addr_select_pin_mid, addr_select_pin_lo};
    addr_s <= addr_m;
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  tsense_pkg::link_state_t state;
  logic [3:0]              cnt;
  logic [7:0]              shift;
  logic [7:0]              msb_hold;
  logic [7:0]              tx;
  logic                    next_lsb;
  logic                    byte_done;
  logic                    addr_hit;
  logic [7:0]              register_select_pointer;
  tsense_pkg::limits_t     lim;
  logic [15:0]             amb_link;
  logic [15:0]             read_word;
  logic                    wr_tgl;

  assign addr_hit  = shift[7:1] == {tsense_pkg::ADDR_FIXED, addr_s};
  assign byte_done = !start_now && state != tsense_pkg::ST_IDLE && cnt == tsense_pkg::ACK_BIT;

  always_comb begin
    unique case (register_select_pointer[1:0])
      tsense_pkg::PTR_AMB:  read_word = amb_link;
      tsense_pkg::PTR_CFG:  read_word = {lim.cfg, lim.cfg};
      tsense_pkg::PTR_HYST: read_word = {lim.hyst, tsense_pkg::LIM_PAD};
      default:              read_word = {lim.upper, tsense_pkg::LIM_PAD};
    endcase
  end

  always_ff @(posedge scl) begin
    if (link_rst) begin
      state     <= tsense_pkg::ST_IDLE;
      cnt       <= 4'h0;
      shift     <= 8'h00;
      msb_hold  <= 8'h00;
      tx        <= 8'h00;
      next_lsb  <= 1'b0;
      start_ack <= 1'b0;
    end else if (start_now) begin
      start_ack <= start_tgl;
      state     <= tsense_pkg::ST_ADDR;
      cnt       <= 4'h1;
      shift     <= {7'h00, sda_in};
    end else if (state == tsense_pkg::ST_IDLE) begin
      cnt <= 4'h0;
    end else if (cnt != tsense_pkg::ACK_BIT) begin
      cnt <= cnt + 4'h1;
      if (state != tsense_pkg::ST_READ) begin
        shift <= {shift[6:0], sda_in};
      end
    end else begin
      cnt <= 4'h0;
      unique case (state)
        tsense_pkg::ST_ADDR: begin
          if (!addr_hit) begin
            state <= tsense_pkg::ST_IDLE;
          end else if (shift[0]) begin
            state    <= tsense_pkg::ST_READ;
            tx       <= read_word[15:8];
            next_lsb <= 1'b1;
          end else begin
            state <= tsense_pkg::ST_WPTR;
          end
        end
        tsense_pkg::ST_WPTR: state <= tsense_pkg::ST_WMSB;
        tsense_pkg::ST_WMSB: begin
          msb_hold <= shift;
          if (register_select_pointer[1:0] != tsense_pkg::PTR_CFG) begin
            state <= tsense_pkg::ST_WLSB;
          end
        end
        tsense_pkg::ST_WLSB: state <= tsense_pkg::ST_WMSB;
        tsense_pkg::ST_READ: begin
          if (sda_in) begin
            state <= tsense_pkg::ST_IDLE;
          end else begin
            tx       <= next_lsb ? read_word[7:0] : read_word[15:8];
            next_lsb <= ~next_lsb;
          end
        end
        default: state <= tsense_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointer and limit registers
  // ----------------------------------------------------------------
  always_ff @(posedge scl) begin
    if (link_rst) begin
      register_select_pointer <= tsense_pkg::PTR_RESET;
    end else if (byte_done && state == tsense_pkg::ST_WPTR) begin
      register_select_pointer <= {6'h00, shift[1:0]};
    end
  end

  always_ff @(posedge scl) begin
    if (link_rst) begin
      lim.cfg   <= tsense_pkg::CFG_RESET;
      lim.hyst  <= tsense_pkg::HYST_RESET;
      lim.upper <= tsense_pkg::UPPER_RESET;
      wr_tgl    <= 1'b0;
    end else if (byte_done) begin
      if (state == tsense_pkg::ST_WMSB && register_select_pointer[1:0] == tsense_pkg::PTR_CFG) begin
        lim.cfg <= shift;
        wr_tgl  <= ~wr_tgl;
      end else if (state == tsense_pkg::ST_WLSB) begin
        // Ambient is read-only; writes to it are dropped
        if (register_select_pointer[1:0] == tsense_pkg::PTR_HYST) begin
          lim.hyst <= {msb_hold, shift[7]};
          wr_tgl   <= ~wr_tgl;
        end else if (register_select_pointer[1:0] == tsense_pkg::PTR_UPPER) begin
          lim.upper <= {msb_hold, shift[7]};
          wr_tgl    <= ~wr_tgl;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Ambient shadow on the link side
  // ----------------------------------------------------------------
  logic                    amb_tgl;
  logic [15:0]             amb_core;
  logic                    amb_m;
  logic                    amb_s;
  logic                    amb_seen;

  always_ff @(posedge scl) begin
    if (link_rst) begin
      amb_m    <= 1'b0;
      amb_s    <= 1'b0;
      amb_seen <= 1'b0;
      amb_link <= tsense_pkg::AMB_RESET;
    end else begin
      amb_m <= amb_tgl;
      amb_s <= amb_m;
      // Held during a read and at byte ends so both bytes come from one result
      if (amb_s != amb_seen && state != tsense_pkg::ST_READ && !byte_done) begin
        amb_seen <= amb_s;
        amb_link <= amb_core;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data drive, changed on the falling edge
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;

  always_ff @(negedge scl) begin
    if (link_rst) begin
      sda_oe <= 1'b0;
    end else if (cnt == tsense_pkg::ACK_BIT) begin
      sda_oe <= (state == tsense_pkg::ST_ADDR && addr_hit) || state == tsense_pkg::ST_WPTR ||
                state == tsense_pkg::ST_WMSB || state == tsense_pkg::ST_WLSB;
    end else begin
      sda_oe <= state == tsense_pkg::ST_READ && !tx[3'(4'h7 - cnt)];
    end
  end

  // ----------------------------------------------------------------
  // Core side: settings crossing and conversion timing
  // ----------------------------------------------------------------
  tsense_pkg::limits_t     core_lim;
  logic                    wr_m;
  logic                    wr_s;
  logic                    wr_seen;
  logic [21:0]             conv_timer;
  logic [21:0]             conv_period;
  logic [1:0]              res;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_m     <= 1'b0;
      wr_s     <= 1'b0;
      wr_seen  <= 1'b0;
      core_lim <= {tsense_pkg::CFG_RESET, tsense_pkg::HYST_RESET, tsense_pkg::UPPER_RESET};
    end else begin
      wr_m <= wr_tgl;
      wr_s <= wr_m;
      if (wr_s != wr_seen) begin
        wr_seen  <= wr_s;
        core_lim <= lim;
      end
    end
  end

  assign res = core_lim.cfg[tsense_pkg::CFG_RES_LSB +: 2];

  always_comb begin
    unique case (res)
      2'h0:    conv_period = 22'(CONV9_CYC);
      2'h1:    conv_period = 22'(CONV10_CYC);
      2'h2:    conv_period = 22'(CONV11_CYC);
      default: conv_period = 22'(CONV12_CYC);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_timer <= 22'h000000;
      conv_start <= 1'b0;
      conv_res   <= 2'h0;
    end else if (conv_timer == 22'h000000) begin
      conv_timer <= conv_period - 22'h000001;
      conv_start <= 1'b1;
      conv_res   <= res;
    end else begin
      conv_timer <= conv_timer - 22'h000001;
      conv_start <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Ambient result and alert
  // ----------------------------------------------------------------
  logic                    amb_over;
  logic                    amb_under;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      amb_core <= tsense_pkg::AMB_RESET;
      amb_tgl  <= 1'b0;
    end else if (conv_done) begin
      amb_core <= conv_data & ~(tsense_pkg::FRAC_MASK >> conv_res);
      amb_tgl  <= ~amb_tgl;
    end
  end

  assign amb_over  = $signed(amb_core[15:7]) > $signed(core_lim.upper);
  assign amb_under = $signed(amb_core[15:7]) < $signed(core_lim.hyst);
  assign alert_out = 1'b0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      alert_oe <= 1'b0;
    end else if (amb_over) begin
      alert_oe <= 1'b1;
    end else if (amb_under) begin
      alert_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_alert_set: assert property (@(posedge core_clk) disable iff (reset) amb_over |=> alert_oe)
    else $error("alert not raised above upper limit");
  a_alert_clear: assert property (@(posedge core_clk) disable iff (reset)
    amb_under && !amb_over |=> !alert_oe)
    else $error("alert not released below hysteresis");
  a_alert_low: assert property (@(posedge core_clk) alert_oe |-> alert_out == 1'b0)
    else $error("alert pin driven high");
  a_amb_load: assert property (@(posedge core_clk) disable iff (reset)
    conv_done |=> amb_core == ($past(conv_data) & ~(tsense_pkg::FRAC_MASK >> $past(conv_res))))
    else $error("ambient not loaded from result");
  a_amb_hold: assert property (@(posedge core_clk) disable iff (reset) !conv_done |=> $stable(amb_core))
    else $error("ambient changed without result");
  a_conv_gap: assert property (@(posedge core_clk) disable iff (reset) conv_start |=> !conv_start [*8])
    else $error("conversions too close");
  a_limit_reset: assert property (@(posedge core_clk) $past(reset) |->
    core_lim.upper == tsense_pkg::UPPER_RESET && core_lim.hyst == tsense_pkg::HYST_RESET)
    else $error("limit reset value wrong");
  a_addr_decide: assert property (@(posedge scl) disable iff (link_rst)
    state == tsense_pkg::ST_ADDR && cnt == tsense_pkg::ACK_BIT && !start_now && !addr_hit
    |=> state inside {tsense_pkg::ST_IDLE, tsense_pkg::ST_ADDR})
    else $error("foreign address accepted");
  a_ptr_write: assert property (@(posedge scl) disable iff (link_rst)
    byte_done && state == tsense_pkg::ST_WPTR |=> register_select_pointer == {6'h00, $past(shift[1:0])})
    else $error("pointer not written");
  a_upper_write: assert property (@(posedge scl) disable iff (link_rst)
    byte_done && state == tsense_pkg::ST_WLSB && register_select_pointer[1:0] == tsense_pkg::PTR_UPPER
    |=> lim.upper == {$past(msb_hold), $past(shift[7])})
    else $error("upper limit not written");
  a_read_first: assert property (@(posedge scl) disable iff (link_rst)
    byte_done && state == tsense_pkg::ST_ADDR && addr_hit && shift[0]
    |=> state == tsense_pkg::ST_READ && tx == $past(read_word[15:8]))
    else $error("read did not start with high byte");

  c_write: cover property (@(posedge scl) byte_done && state == tsense_pkg::ST_WLSB);
  c_read: cover property (@(posedge scl) byte_done && state == tsense_pkg::ST_READ && !sda_in);
  c_alert: cover property (@(posedge core_clk) $rose(alert_oe));
  c_conv: cover property (@(posedge core_clk) conv_done);

endmodule

// ---- inc/tsense_pkg.sv ----
package tsense_pkg;

  // ----------------------------------------------------------------
  // Addressing and pointer
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FIXED  = 4'h9;
  localparam logic [1:0] PTR_AMB     = 2'h0;
  localparam logic [1:0] PTR_CFG     = 2'h1;
  localparam logic [1:0] PTR_HYST    = 2'h2;
  localparam logic [1:0] PTR_UPPER   = 2'h3;
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam logic [3:0] ACK_BIT     = 4'h8;

  // ----------------------------------------------------------------
  // Register reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [8:0]  UPPER_RESET = 9'h0A0;
  localparam logic [8:0]  HYST_RESET  = 9'h096;
  localparam logic [15:0] AMB_RESET   = 16'h0000;
  localparam logic [6:0]  LIM_PAD     = 7'h00;
  localparam int          CFG_RES_LSB = 5;
  localparam logic [15:0] FRAC_MASK   = 16'h007F;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int T9_MS      = 30;
  localparam int T10_MS     = 60;
  localparam int T11_MS     = 120;
  localparam int T12_MS     = 240;

  typedef struct packed {
    logic [7:0] cfg;
    logic [8:0] hyst;
    logic [8:0] upper;
  } limits_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WPTR, ST_WMSB, ST_WLSB, ST_READ} link_state_t;

endpackage

// ---- tb/tsense_host.sv ----
`timescale 1ns/100ps
module tsense_host (
  // Bus lines
  output logic      scl,
  output logic      sda_pull_low,
  input  wire logic sda_line
);
  // ----------------------------------------------------------------
  // Bit level, clock idles high outside frames
  // ----------------------------------------------------------------
  initial begin
    scl          = 1'b1;
    sda_pull_low = 1'b0;
  end

  task automatic pulses(input int n);
    repeat (n) begin
      #15 scl = 1'b0;
      #15 scl = 1'b1;
    end
  endtask

  task automatic start_cond;
    sda_pull_low = 1'b0;
    #5 scl = 1'b1;
    #10 sda_pull_low = 1'b1;
    #15 scl = 1'b0;
  endtask

  task automatic stop_cond;
    #5 sda_pull_low = 1'b1;
    #10 scl = 1'b1;
    #15 sda_pull_low = 1'b0;
    #15;
  endtask

  task automatic send_bit(input logic b);
    #5 sda_pull_low = ~b;
    #10 scl = 1'b1;
    #15 scl = 1'b0;
  endtask

  task automatic recv_bit(output logic b);
    #5 sda_pull_low = 1'b0;
    #10 scl = 1'b1;
    b = sda_line;
    #15 scl = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Byte and transaction level
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
    recv_bit(b);
    ack = ~b;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) recv_bit(v[i]);
    send_bit(~more);
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [1:0] sel, input int n, input logic [15:0] d,
                           output logic ok);
    logic ack;
    start_cond();
    send_byte({a, 1'b0}, ok);
    if (ok) begin
      send_byte({6'h00, sel}, ack);
      ok = ack;
      if (n == 2) begin
        send_byte(d[15:8], ack);
        ok = ok & ack;
      end
      if (n >= 1) begin
        send_byte(d[7:0], ack);
        ok = ok & ack;
      end
    end
    stop_cond();
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [15:0] d, output logic ok);
    d = 16'h0000;
    start_cond();
    send_byte({a, 1'b1}, ok);
    if (ok) begin
      recv_byte(1'b1, d[15:8]);
      recv_byte(1'b0, d[7:0]);
    end
    stop_cond();
  endtask
endmodule

// ---- tb/temp_sensor_register_access_tb.sv ----
`timescale 1ns/100ps
module temp_sensor_register_access_tb;
  localparam int         C9  = 16;
  localparam int         C10 = 24;
  localparam int         C11 = 32;
  localparam int         C12 = 48;
  localparam logic [6:0] DEV = {tsense_pkg::ADDR_FIXED, 3'h5};

  logic        core_clk;
  logic        reset = 1'b0;
  logic        scl;
  logic        host_low;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  pins;
  logic        alert_out;
  logic        alert_oe;
  logic        alert_pin;
  logic        conv_start;
  logic [1:0]  conv_res;
  logic        conv_done;
  logic [15:0] conv_data;
  int          fails;
  int          check_count;

  // ----------------------------------------------------------------
  // Pins with pull-ups, device and host
  // ----------------------------------------------------------------
  assign sda_line  = ~(host_low | (sda_oe & ~sda_out));
  assign alert_pin = ~(alert_oe & ~alert_out);

  temp_sensor_register_access #(.CONV9_CYC(C9), .CONV10_CYC(C10), .CONV11_CYC(C11), .CONV12_CYC(C12)) DUT (
    .core_clk(core_clk), .reset(reset), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_pin_hi(pins[2]), .addr_select_pin_mid(pins[1]), .addr_select_pin_lo(pins[0]),
    .alert_out(alert_out), .alert_oe(alert_oe), .conv_start(conv_start), .conv_res(conv_res),
    .conv_done(conv_done), .conv_data(conv_data));

  tsense_host host (.scl(scl), .sda_pull_low(host_low), .sda_line(sda_line));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [1:0] sel, input int n, input logic [15:0] d);
    logic ok;
    host.write_reg(DEV, sel, n, d, ok);
    check({15'h0000, ok}, 16'h0001, "write acked");
    repeat (5) @(posedge core_clk);
  endtask

  task automatic rd(input logic [1:0] sel, output logic [15:0] d);
    logic ok;
    wr(sel, 0, 16'h0000);
    host.read_reg(DEV, d, ok);
    check({15'h0000, ok}, 16'h0001, "read acked");
  endtask

  task automatic pulse_conv(input logic [15:0] d);
    @(posedge core_clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_start(input logic [1:0] r, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (!(conv_start === 1'b1 && conv_res === r) && n < 300);
    if (n >= 300) begin
      fails++;
      $display("Error at %0t: no conversion start", $time);
      report_and_stop();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    logic [15:0] d;
    logic        ok;
    host.read_reg(DEV, d, ok);
    check({15'h0000, ok}, 16'h0001, "first read acked");
    check(d, 16'h0000, "ambient via reset pointer");
    check({15'h0000, sda_out}, 16'h0000, "data pin only pulls low");
    rd(tsense_pkg::PTR_HYST, d);
    check(d, 16'h4B00, "hysteresis reset");
    rd(tsense_pkg::PTR_UPPER, d);
    check(d, 16'h5000, "upper reset");
    rd(tsense_pkg::PTR_CFG, d);
    check(d, 16'h0000, "config reset");
    check({15'h0000, alert_oe}, 16'h0000, "alert idle");
  endtask

  task automatic t_address;
    logic [6:0] bad [3] = '{7'h45, 7'h4C, 7'h1D};
    logic       ok;
    foreach (bad[i]) begin
      host.write_reg(bad[i], tsense_pkg::PTR_CFG, 1, 16'h0060, ok);
      check({15'h0000, ok}, 16'h0000, "foreign address");
    end
  endtask

  task automatic t_limits;
    logic [15:0] d;
    logic        ok;
    wr(tsense_pkg::PTR_UPPER, 2, 16'h1234);
    rd(tsense_pkg::PTR_UPPER, d);
    check(d, 16'h1200, "upper nine bits");
    wr(tsense_pkg::PTR_HYST, 2, 16'hFFFF);
    rd(tsense_pkg::PTR_HYST, d);
    check(d, 16'hFF80, "hysteresis nine bits");
    host.read_reg(DEV, d, ok);
    check(d, 16'hFF80, "pointer kept");
    wr(tsense_pkg::PTR_AMB, 2, 16'hABCD);
    rd(tsense_pkg::PTR_AMB, d);
    check(d, 16'h0000, "ambient not writable");
  endtask

  task automatic t_alert;
    logic [15:0] d;
    wr(tsense_pkg::PTR_UPPER, 2, 16'h1900);
    wr(tsense_pkg::PTR_HYST, 2, 16'h1400);
    pulse_conv(16'h1A5F);
    check({14'h0000, alert_oe, alert_pin}, 16'h0002, "alert above upper");
    check({15'h0000, alert_out}, 16'h0000, "alert never high");
    rd(tsense_pkg::PTR_AMB, d);
    check(d, 16'h1A00, "ambient loaded");
    pulse_conv(16'h1500);
    check({15'h0000, alert_oe}, 16'h0001, "alert held in band");
    pulse_conv(16'h1300);
    check({14'h0000, alert_oe, alert_pin}, 16'h0001, "alert below hysteresis");
    pulse_conv(16'hE690);
    rd(tsense_pkg::PTR_AMB, d);
    check(d, 16'hE680, "negative ambient");
  endtask

  task automatic t_resolution;
    int          per [4] = '{C9, C10, C11, C12};
    int          n;
    logic [15:0] d;
    for (int r = 0; r < 4; r++) begin
      wr(tsense_pkg::PTR_CFG, 1, {9'h000, r[1:0], 5'h00});
      wait_start(r[1:0], n);
      wait_start(r[1:0], n);
      check(n[15:0], per[r][15:0], "conversion period");
    end
    rd(tsense_pkg::PTR_CFG, d);
    check(d, 16'h6060, "config both bytes");
  endtask

  initial begin
    reset       <= 1'b1;
    conv_done   = 1'b0;
    conv_data   = 16'h0000;
    pins        = 3'h5;
    fails       = 0;
    check_count = 0;
    host.pulses(4);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // Link reset only lifts after scl edges with reset low
    host.pulses(4);
    repeat (3) @(posedge core_clk);
    t_reset_values();
    t_address();
    t_limits();
    t_alert();
    t_resolution();
    report_and_stop();
  end
endmodule
